// File: pkg/wcb_defs.svh
// Bit positions, reset values and memory addresses of the wiper configuration bank.
// Assumes it is included by bare name from the design files.
`ifndef WCB_DEFS_SVH
`define WCB_DEFS_SVH

// Control register bit positions.
`define WCB_CTRL_WP_BIT 0
`define WCB_CTRL_PGM_BIT 1
`define WCB_CTRL_LIN_BIT 2
`define WCB_CTRL_BURST_BIT 3

// Control register value after the power-on preset.
`define WCB_CTRL_RESET 4'h3

// Memory map addresses.
`define WCB_ADDR_WB 2'h0
`define WCB_ADDR_AW 2'h1
`define WCB_ADDR_TOL_HI 2'h2
`define WCB_ADDR_TOL_LO 2'h3

// Sign bit of the tolerance high byte; 1 means positive.
`define WCB_TOL_SIGN_BIT 7

`endif

// File: pkg/wcb_pkg.sv
// Types shared by the wiper configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package wcb_pkg;

   // Preset sequencer states.
   typedef enum logic [1:0] {
      WCB_PRE_REQ = 2'b00,
      WCB_PRE_WB = 2'b01,
      WCB_PRE_AW = 2'b10,
      WCB_IDLE = 2'b11
   } wcb_state_e;

   typedef logic [3:0] wcb_ctrl_t;

endpackage

// File: rtl/wcb_nvm.sv
// Small nonvolatile store: two wiper words and the read-only tolerance bytes.
// Assumes writes come only from the bank's own logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "wcb_defs.svh"
module wcb_nvm
   import wcb_pkg::*;
#(
   parameter int WIPER_BITS = 8,
   parameter logic [7:0] TOL_HI = 8'h80,
   parameter logic [7:0] TOL_LO = 8'h00,
   parameter logic [7:0] INIT_CODE = 8'h80
)
(
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset of the read port only.
   input wire logic we_i, // Store both wiper words.
   input wire logic [WIPER_BITS-1:0] wb_i, // Wiper-to-B code to store.
   input wire logic [WIPER_BITS-1:0] aw_i, // Wiper-to-A code to store.
   input wire logic re_i, // Read request.
   input wire logic [1:0] raddr_i, // Read address.
   output logic [7:0] rdata_o // Registered read data.
);

   // Stored words keep their value across reset, as a nonvolatile cell would.
   logic [WIPER_BITS-1:0] store_wb = INIT_CODE[WIPER_BITS-1:0];
   logic [WIPER_BITS-1:0] store_aw = INIT_CODE[WIPER_BITS-1:0];
   logic [WIPER_BITS-1:0] next_store_wb;
   logic [WIPER_BITS-1:0] next_store_aw;
   logic [7:0] next_rdata;

   // Next contents and read data; the tolerance bytes are fixed.
   always_comb
   begin
      next_store_wb = we_i ? wb_i : store_wb;
      next_store_aw = we_i ? aw_i : store_aw;
      next_rdata = rdata_o;
      if (re_i)
      begin
         if (raddr_i == `WCB_ADDR_WB)
            next_rdata = 8'(store_wb);
         else if (raddr_i == `WCB_ADDR_AW)
            next_rdata = 8'(store_aw);
         else if (raddr_i == `WCB_ADDR_TOL_HI)
            next_rdata = TOL_HI; // R10
         else
            next_rdata = TOL_LO; // R11
      end
   end

   // Registers the store and the read port.
   always_ff @(posedge clk_i)
   begin
      store_wb <= next_store_wb;
      store_aw <= next_store_aw;
      if (rst_i)
         rdata_o <= 8'h00;
      else
         rdata_o <= next_rdata;
   end

endmodule
`default_nettype wire

// File: rtl/wcb_bank.sv
// Configuration bank of a single-channel digital potentiometer: control
// register, wiper latches, tap decoding and tolerance read-back.
// Assumes a command decoder on the same clock drives the request strobes.
//
// Operation
// (R1) With write protect at 0 the wiper stays at its stored value and interface writes are ignored; 1 allows them. Scale commands are still accepted at 0.
// (R2) Programming the stored wiper values is blocked while the program enable bit is 0 and allowed when it is 1.
// (R3) The mode bit selects potentiometer mode at 0 and linear gain setting mode at 1.
// (R4) The burst bit, meaningful only on the two-wire bus, keeps burst mode on across stop and repeated start.
// (R5) The wiper code is decoded so that each code selects exactly one of 128 or 256 taps.
// (R6) In potentiometer mode the wiper-to-B value rises with the code and wiper-to-A is its complement.
// (R7) In linear gain setting mode wiper-to-A follows its own wiper register directly.
// (R8) Bottom scale and top scale are extra positions, and top scale lowers wiper-to-A by one step.
// (R9) A factory tolerance is kept as a 16-bit sign-magnitude value readable by the host.
// (R10) Tolerance_sign_integer holds the sign in its top bit (1 positive) and the integer percent below it.
// (R11) Tolerance_fraction holds eight fraction bits of the tolerance.
// (R12) After reset a preset sequence loads the stored values into the wiper registers.
// (R13) After reset the control register reads 0x3.
`timescale 1ns/1ps
`default_nettype none
`include "wcb_defs.svh"
module wcb_bank
   import wcb_pkg::*;
#(
   parameter int WIPER_BITS = 8,
   parameter logic [7:0] TOL_HI = 8'h80, // Arbitrary factory value.
   parameter logic [7:0] TOL_LO = 8'h00, // Arbitrary factory value.
   parameter logic [7:0] INIT_CODE = 8'h80
)
(
   input wire logic CLK_I, // 250 MHz clock.
   input wire logic RST_I, // Synchronous power-on preset, active high.
   input wire logic CTRL_WE_I, // Control register write strobe.
   input wire logic [3:0] CTRL_DATA_I, // Control register write data.
   input wire logic WIPER_WE_I, // Wiper write strobe.
   input wire logic WIPER_SEL_I, // 0 selects wiper-to-B, 1 wiper-to-A.
   input wire logic [WIPER_BITS-1:0] WIPER_CODE_I, // Wiper write code.
   input wire logic WIPER_STORE_I, // Copy wipers to the store.
   input wire logic WIPER_RESTORE_I, // Reload wipers from the store.
   input wire logic SCALE_WE_I, // Scale position command strobe.
   input wire logic SCALE_TOP_I, // 1 top scale, 0 bottom scale.
   input wire logic SCALE_ENTER_I, // 1 enter, 0 exit.
   input wire logic I2C_SEL_I, // Two-wire bus in use.
   input wire logic MEM_RD_I, // Memory read strobe.
   input wire logic [1:0] MEM_ADDR_I, // Memory read address.
   output logic [3:0] CTRL_O, // Control register contents.
   output logic BURST_MODE_O, // Burst mode active.
   output logic LINEAR_MODE_O, // Linear gain setting mode.
   output logic [(1<<WIPER_BITS)-1:0] TAP_WB_O, // One-hot wiper tap.
   output logic [WIPER_BITS:0] RAW_CODE_O, // Wiper-to-A resistance code.
   output logic TOP_SCALE_O, // Top scale position.
   output logic BOTTOM_SCALE_O, // Bottom scale position.
   output logic PRESET_BUSY_O, // Preset or restore running.
   output logic [7:0] MEM_DATA_O, // Memory read data.
   output logic MEM_VALID_O // Read data valid pulse.
);

   localparam int TAPS = 1 << WIPER_BITS;
   localparam logic [WIPER_BITS:0] FULL = (WIPER_BITS+1)'(TAPS);

   // Only the 128- and 256-position variants exist.
   if (WIPER_BITS != 7 && WIPER_BITS != 8)
      $error("WIPER_BITS must be 7 or 8");

   wcb_state_e state;
   wcb_state_e next_state;
   wcb_ctrl_t ctrl;
   wcb_ctrl_t next_ctrl;
   logic [WIPER_BITS-1:0] wiper_wb;
   logic [WIPER_BITS-1:0] wiper_aw;
   logic [WIPER_BITS-1:0] next_wiper_wb;
   logic [WIPER_BITS-1:0] next_wiper_aw;
   logic next_top;
   logic next_bot;
   logic next_valid;
   logic nvm_we;
   logic nvm_re;
   logic [1:0] nvm_addr;
   logic [7:0] nvm_rdata;
   logic idle;

   assign idle = (state == WCB_IDLE);

   // Preset sequencer and memory port steering.
   always_comb
   begin
      next_state = state;
      nvm_re = 1'b0;
      nvm_addr = MEM_ADDR_I;
      nvm_we = 1'b0;
      next_valid = 1'b0;
      case (state)
         WCB_PRE_REQ:
         begin
            nvm_re = 1'b1; // R12
            nvm_addr = `WCB_ADDR_WB;
            next_state = WCB_PRE_WB;
         end
         WCB_PRE_WB:
         begin
            nvm_re = 1'b1; // R12
            nvm_addr = `WCB_ADDR_AW;
            next_state = WCB_PRE_AW;
         end
         WCB_PRE_AW:
            next_state = WCB_IDLE;
         default:
         begin
            nvm_re = MEM_RD_I; // R9
            next_valid = MEM_RD_I;
            nvm_we = WIPER_STORE_I & ctrl[`WCB_CTRL_PGM_BIT]; // R2
            if (WIPER_RESTORE_I || (CTRL_WE_I && !CTRL_DATA_I[`WCB_CTRL_WP_BIT]))
               next_state = WCB_PRE_REQ; // R1
         end
      endcase
   end

   // Control register and wiper latches.
   always_comb
   begin
      next_ctrl = ctrl;
      next_wiper_wb = wiper_wb;
      next_wiper_aw = wiper_aw;
      next_top = TOP_SCALE_O;
      next_bot = BOTTOM_SCALE_O;
      if (state == WCB_PRE_WB)
         next_wiper_wb = nvm_rdata[WIPER_BITS-1:0]; // R12
      else if (state == WCB_PRE_AW)
         next_wiper_aw = nvm_rdata[WIPER_BITS-1:0]; // R12
      else
      begin
         if (CTRL_WE_I)
            next_ctrl = CTRL_DATA_I; // R3
         if (WIPER_WE_I && ctrl[`WCB_CTRL_WP_BIT] && !WIPER_RESTORE_I)
         begin
            if (WIPER_SEL_I)
               next_wiper_aw = WIPER_CODE_I; // R7
            else
               next_wiper_wb = WIPER_CODE_I; // R1
            next_top = 1'b0;
            next_bot = 1'b0;
         end
         else if (SCALE_WE_I)
         begin
            next_top = SCALE_TOP_I & SCALE_ENTER_I; // R8
            next_bot = !SCALE_TOP_I & SCALE_ENTER_I; // R8
         end
      end
   end

   // Decoded outputs computed from the next latch values.
   logic [(1<<WIPER_BITS)-1:0] next_tap;
   logic [WIPER_BITS:0] next_raw;
   always_comb
   begin
      next_tap = '0;
      if (next_top)
         next_tap[TAPS-1] = 1'b1; // R8
      else if (next_bot)
         next_tap[0] = 1'b1; // R8
      else
         next_tap[next_wiper_wb] = 1'b1; // R5
      if (next_ctrl[`WCB_CTRL_LIN_BIT])
         next_raw = {1'b0, next_wiper_aw}; // R7
      else
         next_raw = FULL - {1'b0, next_wiper_wb}; // R6
      if (next_top && next_raw != '0)
         next_raw = next_raw - (WIPER_BITS+1)'(1); // R8
   end

   // Registers every piece of state and every output except MEM_DATA_O, which is the store's registered read port.
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         state <= WCB_PRE_REQ; // R12
         ctrl <= `WCB_CTRL_RESET; // R13
         wiper_wb <= '0;
         wiper_aw <= '0;
         CTRL_O <= `WCB_CTRL_RESET; // R13
         BURST_MODE_O <= 1'b0;
         LINEAR_MODE_O <= 1'b0;
         TAP_WB_O <= (1<<WIPER_BITS)'(1);
         RAW_CODE_O <= FULL;
         TOP_SCALE_O <= 1'b0;
         BOTTOM_SCALE_O <= 1'b0;
         PRESET_BUSY_O <= 1'b1;
         MEM_VALID_O <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ctrl <= next_ctrl;
         wiper_wb <= next_wiper_wb;
         wiper_aw <= next_wiper_aw;
         CTRL_O <= next_ctrl;
         BURST_MODE_O <= next_ctrl[`WCB_CTRL_BURST_BIT] & I2C_SEL_I; // R4
         LINEAR_MODE_O <= next_ctrl[`WCB_CTRL_LIN_BIT]; // R3
         TAP_WB_O <= next_tap;
         RAW_CODE_O <= next_raw;
         TOP_SCALE_O <= next_top;
         BOTTOM_SCALE_O <= next_bot;
         PRESET_BUSY_O <= (next_state != WCB_IDLE);
         MEM_VALID_O <= next_valid;
      end
   end

   // Stored wipers and read-only tolerance bytes.
   wcb_nvm #(
      .WIPER_BITS(WIPER_BITS),
      .TOL_HI(TOL_HI),
      .TOL_LO(TOL_LO),
      .INIT_CODE(INIT_CODE)
   ) u_nvm (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .we_i(nvm_we),
      .wb_i(wiper_wb),
      .aw_i(wiper_aw),
      .re_i(nvm_re),
      .raddr_i(nvm_addr),
      .rdata_o(nvm_rdata)
   );

   assign MEM_DATA_O = nvm_rdata;

   // Preset walk taken after each reset release.
   sequence s_preset_walk;
      state == WCB_PRE_REQ ##1 state == WCB_PRE_WB ##1 state == WCB_PRE_AW ##1 state == WCB_IDLE;
   endsequence

   sequence s_tol_hi_read;
      idle && MEM_RD_I && MEM_ADDR_I == `WCB_ADDR_TOL_HI;
   endsequence

   // Control register value right after reset.
   a_ctrl_reset_value: assert property (@(posedge CLK_I) disable iff (RST_I) // R13
      $past(RST_I) |-> CTRL_O == `WCB_CTRL_RESET && ctrl == `WCB_CTRL_RESET)
      else $error("control register not at reset value");

   // Preset walks through its states, ends in idle and loads wiper-to-A.
   a_preset_load_walk: assert property (@(posedge CLK_I) disable iff (RST_I) // R12
      $past(RST_I) |-> s_preset_walk ##0 (!PRESET_BUSY_O && wiper_aw == $past(nvm_rdata[WIPER_BITS-1:0])))
      else $error("preset sequence did not load wipers");

   // Write protect freezes the wiper.
   a_wp_blocks_write: assert property (@(posedge CLK_I) disable iff (RST_I) // R1
      idle && !ctrl[`WCB_CTRL_WP_BIT] && WIPER_WE_I && !CTRL_WE_I && !WIPER_RESTORE_I
      |=> $stable(wiper_wb) && $stable(wiper_aw))
      else $error("wiper changed while write protected");

   // Program enable gates the store.
   a_pgm_gates_store: assert property (@(posedge CLK_I) disable iff (RST_I) // R2
      nvm_we |-> idle && ctrl[`WCB_CTRL_PGM_BIT] && WIPER_STORE_I)
      else $error("store written while programming disabled");

   // Stored words stay put while programming is disabled.
   a_pgm_blocks_store: assert property (@(posedge CLK_I) disable iff (RST_I) // R2
      !ctrl[`WCB_CTRL_PGM_BIT] |=> $stable(u_nvm.store_wb) && $stable(u_nvm.store_aw))
      else $error("store changed while programming disabled");

   // Burst mode turns on when its bit is set on the two-wire bus.
   a_burst_mode_on: assert property (@(posedge CLK_I) disable iff (RST_I) // R4
      ctrl[`WCB_CTRL_BURST_BIT] && I2C_SEL_I && !CTRL_WE_I |=> BURST_MODE_O)
      else $error("burst mode not active");

   // Exactly one tap is selected.
   a_tap_onehot: assert property (@(posedge CLK_I) disable iff (RST_I) // R5
      $onehot(TAP_WB_O))
      else $error("tap select not one-hot");

   // Potentiometer mode complement.
   a_pot_complement: assert property (@(posedge CLK_I) disable iff (RST_I) // R6
      !LINEAR_MODE_O && !TOP_SCALE_O && !BOTTOM_SCALE_O
      |-> RAW_CODE_O + {1'b0, wiper_wb} == FULL && TAP_WB_O[wiper_wb])
      else $error("wiper-to-A not the complement");

   // Linear mode uses its own register.
   a_linear_direct: assert property (@(posedge CLK_I) disable iff (RST_I) // R7
      LINEAR_MODE_O && !TOP_SCALE_O |-> RAW_CODE_O == {1'b0, wiper_aw})
      else $error("linear mode wiper-to-A wrong");

   // Top scale removes one step.
   a_top_scale_lsb: assert property (@(posedge CLK_I) disable iff (RST_I) // R8
      TOP_SCALE_O && !LINEAR_MODE_O |-> RAW_CODE_O == FULL - {1'b0, wiper_wb} - 1 && TAP_WB_O[TAPS-1])
      else $error("top scale not one step lower");

   // Tolerance bytes read back a cycle later.
   a_tol_read_back: assert property (@(posedge CLK_I) disable iff (RST_I) // R10
      s_tol_hi_read |=> MEM_VALID_O && MEM_DATA_O == TOL_HI ##0 MEM_DATA_O[`WCB_TOL_SIGN_BIT] == TOL_HI[7])
      else $error("tolerance high byte wrong");

   a_tol_frac_read: assert property (@(posedge CLK_I) disable iff (RST_I) // R11
      idle && MEM_RD_I && MEM_ADDR_I == `WCB_ADDR_TOL_LO |=> MEM_VALID_O && MEM_DATA_O == TOL_LO)
      else $error("tolerance fraction byte wrong");

endmodule
`default_nettype wire

// File: sim/wcb_host_model.sv
// Host-side command model of the wiper configuration bank.
// Assumes the bench calls its tasks and that every input change lands on a falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module wcb_host_model
   import wcb_pkg::*;
#(
   parameter int WIPER_BITS = 8
)
(
   input wire logic clk_i, // Bank clock.
   input wire logic [7:0] mem_data_i, // Read data from the bank.
   input wire logic mem_valid_i, // Read data valid pulse.
   output logic rst_o, // Preset request.
   output logic ctrl_we_o, // Control write strobe.
   output logic [3:0] ctrl_data_o, // Control write data.
   output logic wiper_we_o, // Wiper write strobe.
   output logic wiper_sel_o, // Wiper register select.
   output logic [WIPER_BITS-1:0] wiper_code_o, // Wiper code.
   output logic store_o, // Store request.
   output logic restore_o, // Restore request.
   output logic scale_we_o, // Scale command strobe.
   output logic scale_top_o, // Top or bottom scale.
   output logic scale_enter_o, // Enter or exit.
   output logic i2c_sel_o, // Two-wire bus in use.
   output logic mem_rd_o, // Memory read strobe.
   output logic [1:0] mem_addr_o // Memory read address.
);
   // Every line starts in reset with all strobes low.
   initial
   begin
      {ctrl_we_o, ctrl_data_o, wiper_we_o, wiper_sel_o, wiper_code_o} = '0;
      {store_o, restore_o, scale_we_o, scale_top_o, scale_enter_o, i2c_sel_o, mem_rd_o, mem_addr_o} = '0;
      rst_o = 1'b1;
   end

   // Holds the preset request for a number of cycles.
   task automatic hold_reset(input int n);
      rst_o = 1'b1;
      repeat (n) @(negedge clk_i);
      rst_o = 1'b0;
   endtask

   // Writes the control register; idle data lines carry the inverse so stale values never match.
   task automatic ctrl_write(input logic [3:0] d);
      @(negedge clk_i);
      ctrl_we_o = 1'b1;
      ctrl_data_o = d;
      @(negedge clk_i);
      ctrl_we_o = 1'b0;
      ctrl_data_o = ~d;
   endtask

   // Writes one wiper register.
   task automatic wiper_write(input logic sel, input logic [WIPER_BITS-1:0] c);
      @(negedge clk_i);
      wiper_we_o = 1'b1;
      wiper_sel_o = sel;
      wiper_code_o = c;
      @(negedge clk_i);
      wiper_we_o = 1'b0;
      wiper_code_o = ~c;
   endtask

   // Copies both wipers into the store.
   task automatic store();
      @(negedge clk_i);
      store_o = 1'b1;
      @(negedge clk_i);
      store_o = 1'b0;
   endtask

   // Reloads both wipers from the store.
   task automatic restore();
      @(negedge clk_i);
      restore_o = 1'b1;
      @(negedge clk_i);
      restore_o = 1'b0;
   endtask

   // Enters or leaves a scale position.
   task automatic scale(input logic top, input logic enter);
      @(negedge clk_i);
      scale_we_o = 1'b1;
      scale_top_o = top;
      scale_enter_o = enter;
      @(negedge clk_i);
      scale_we_o = 1'b0;
   endtask

   // Changes the bus selection level.
   task automatic set_i2c(input logic v);
      @(negedge clk_i);
      i2c_sel_o = v;
   endtask

   // Reads one memory byte; the answer is taken one cycle after the request.
   task automatic mem_read(input logic [1:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_i);
      mem_rd_o = 1'b1;
      mem_addr_o = a;
      @(negedge clk_i);
      mem_rd_o = 1'b0;
      mem_addr_o = ~a;
      d = mem_data_i;
      v = mem_valid_i;
   endtask
endmodule
`default_nettype wire

// File: sim/wcb_bank_bench.sv
// Self-checking bench of the wiper configuration bank.
// Assumes the host model drives every bank input on falling edges.
`timescale 1ns/1ps
`default_nettype none
module wcb_bank_bench;
   import wcb_pkg::*;
   logic clk;
   logic rst, cwe, wwe, wsel, wst, wrs, swe, stop, sent, i2c, mrd, burst, lin, tops, bots, busy, mval, rv;
   logic [3:0] cdat;
   logic [3:0] ctrl;
   logic [7:0] wcode;
   logic [7:0] mdat;
   logic [7:0] rd;
   logic [1:0] maddr;
   logic [255:0] tap;
   logic [8:0] raw;
   int miscompares = 0;
   int samples_checked = 0;
   int codes[3] = '{0, 5, 255};

   // Clock of 4 ns period.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Tolerance bytes are arbitrary factory values.
   wcb_bank #(.WIPER_BITS(8), .TOL_HI(8'h02), .TOL_LO(8'hb0), .INIT_CODE(8'h80)) u_dut (
      .CLK_I(clk), .RST_I(rst), .CTRL_WE_I(cwe), .CTRL_DATA_I(cdat), .WIPER_WE_I(wwe),
      .WIPER_SEL_I(wsel), .WIPER_CODE_I(wcode), .WIPER_STORE_I(wst), .WIPER_RESTORE_I(wrs),
      .SCALE_WE_I(swe), .SCALE_TOP_I(stop), .SCALE_ENTER_I(sent), .I2C_SEL_I(i2c), .MEM_RD_I(mrd),
      .MEM_ADDR_I(maddr), .CTRL_O(ctrl), .BURST_MODE_O(burst), .LINEAR_MODE_O(lin), .TAP_WB_O(tap),
      .RAW_CODE_O(raw), .TOP_SCALE_O(tops), .BOTTOM_SCALE_O(bots), .PRESET_BUSY_O(busy),
      .MEM_DATA_O(mdat), .MEM_VALID_O(mval));

   wcb_host_model #(.WIPER_BITS(8)) u_host (
      .clk_i(clk), .mem_data_i(mdat), .mem_valid_i(mval), .rst_o(rst), .ctrl_we_o(cwe),
      .ctrl_data_o(cdat), .wiper_we_o(wwe), .wiper_sel_o(wsel), .wiper_code_o(wcode), .store_o(wst),
      .restore_o(wrs), .scale_we_o(swe), .scale_top_o(stop), .scale_enter_o(sent), .i2c_sel_o(i2c),
      .mem_rd_o(mrd), .mem_addr_o(maddr));

   // Compares a seen value with its expectation.
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One-hot tap pattern for a code.
   function automatic logic [255:0] hot(input int c);
      hot = '0;
      hot[c] = 1'b1;
   endfunction

   // Waits a bounded time for the preset sequence to finish.
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      check(busy, 1'b0);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Cuts a hang short.
   initial
   begin
      #40000;
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test();
   end

   // Main sequence.
   initial
   begin
      u_host.hold_reset(5);
      check(ctrl, 4'h3);
      wait_idle();
      check(tap, hot(8'h80));
      check(raw, 9'h080);
      u_host.mem_read(2'h2, rd, rv);
      check(rv, 1'b1);
      check(rd, 8'h02);
      u_host.mem_read(2'h3, rd, rv);
      check(rd, 8'hb0);
      @(negedge clk);
      check(mval, 1'b0);
      foreach (codes[i])
      begin
         u_host.wiper_write(1'b0, codes[i][7:0]);
         check(tap, hot(codes[i]));
         check(raw, 256 - codes[i]);
      end
      u_host.ctrl_write(4'hb);
      u_host.set_i2c(1'b1);
      @(negedge clk);
      check(burst, 1'b1);
      check(lin, 1'b0);
      u_host.set_i2c(1'b0);
      @(negedge clk);
      check(burst, 1'b0);
      u_host.ctrl_write(4'h7);
      check(lin, 1'b1);
      u_host.wiper_write(1'b1, 8'h40);
      check(raw, 9'h040);
      u_host.scale(1'b1, 1'b1);
      check(tops, 1'b1);
      check(tap, hot(255));
      check(raw, 9'h03f);
      u_host.scale(1'b1, 1'b0);
      check(tops, 1'b0);
      u_host.scale(1'b0, 1'b1);
      check(bots, 1'b1);
      check(tap, hot(0));
      u_host.scale(1'b0, 1'b0);
      check(bots, 1'b0);
      u_host.ctrl_write(4'h1);
      u_host.wiper_write(1'b0, 8'h22);
      u_host.store();
      u_host.mem_read(2'h0, rd, rv);
      check(rd, 8'h80);
      u_host.ctrl_write(4'h3);
      u_host.store();
      u_host.mem_read(2'h0, rd, rv);
      check(rd, 8'h22);
      u_host.mem_read(2'h1, rd, rv);
      check(rd, 8'h40);
      u_host.wiper_write(1'b0, 8'h66);
      u_host.restore();
      wait_idle();
      check(tap, hot(8'h22));
      check(raw, 9'h0de);
      u_host.wiper_write(1'b0, 8'h66);
      u_host.ctrl_write(4'h2);
      wait_idle();
      check(tap, hot(8'h22));
      u_host.wiper_write(1'b0, 8'h10);
      check(tap, hot(8'h22));
      u_host.ctrl_write(4'h3);
      u_host.wiper_write(1'b0, 8'h10);
      check(tap, hot(8'h10));
      u_host.ctrl_write(4'hd);
      u_host.hold_reset(5);
      check(ctrl, 4'h3);
      wait_idle();
      check(tap, hot(8'h22));
      finish_test();
   end
endmodule
`default_nettype wire
